// [hdl/byte_handshake_cfg.svh]
// constants for the instrument bus byte handshake
`ifndef BYTE_HANDSHAKE_CFG_SVH
`define BYTE_HANDSHAKE_CFG_SVH
`define REG_CAUSE 2'h0
`define REG_STATE 2'h1
`define REG_MASK 2'h2
`define REG_DATA 2'h3
`define CAUSE_IN_BIT 0
`define CAUSE_OUT_BIT 1
`define IRQ_W 2
`define STATE_TALK_BIT 0
`define STATE_LISTEN_BIT 1
`define STATE_POLL_BIT 2
`define MASK_RESET 2'h0
`endif

// [hdl/byte_handshake_device.sv]
// device end: acceptor and source handshakes with processor registers
//
// Behaviour
// [R1] acceptor active under attention or listen state
// [R2] talker settles byte before asserting valid
// [R3] valid through two stages opens decode
// [R4] decode sets input flag, drops ready, latches
// [R5] interrupt asserted together with byte latch
// [R6] decode closes, then data accepted rises
// [R7] valid released, data accepted returns low
// [R8] processor reads cause, then input byte
// [R9] input byte read clears flag, raises ready
// [R10] processor writes output only when done
// [R11] output write clears done, valid follows
// [R12] done low and ready high set stage
// [R13] synchronised accepted with valid sets done
// [R14] done set drops valid next edge
// [R15] no new valid until ready high
// [R16] listener raises accepted, drops ready
// [R17] output drivers only talk, attention high
// [R18] decode enable lasts exactly one period
// [R19] reset clears valid stages, sets done and source stage, idle
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "byte_handshake_cfg.svh"
module byte_handshake_device (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // processor register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_interrupt_request_n,
  // addressing state from the decode logic
  input wire logic i_talk,
  input wire logic i_listen,
  input wire logic i_serial_poll_flag,
  // bus side
  byte_link_if.device bus
);
  // ****************************************
  // acceptor side
  // ****************************************
  logic acc_enable;
  logic src_enable;
  logic valid_s1;
  logic valid_s2;
  logic decode_en;
  logic input_data_flag;
  byte_handshake_pkg::byte_t byte_in_register;
  logic rd_data;
  assign acc_enable = !bus.attention_line_n || i_listen; // [R1]
  assign rd_data = i_rd && (i_addr == `REG_DATA);
  // second stage read by decode, accepted and the update logic of both stages
  assign decode_en = valid_s1 && !valid_s2; // [R3] [R18]
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valid_s1 <= 1'b0; // [R19]
      valid_s2 <= 1'b0;
    end else begin
      // stage one is a one-edge pulse so decode lasts a single period
      valid_s1 <= acc_enable && !bus.data_valid_line_n && !valid_s1 && !valid_s2
                  && !input_data_flag; // [R3] [R6]
      valid_s2 <= acc_enable && !bus.data_valid_line_n && (valid_s1 || valid_s2); // [R7]
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      input_data_flag <= 1'b0; // [R19]
      byte_in_register <= 8'h00;
    end else if (decode_en) begin
      input_data_flag <= 1'b1; // [R4]
      byte_in_register <= bus.dio;
    end else if (rd_data) begin
      input_data_flag <= 1'b0; // [R9]
    end
  end
  // accepted while stage two holds and decode closed
  // a talking device releases accepted so the wired-and only hears the listener
  assign bus.data_accepted_dev = (valid_s2 && !valid_s1) || src_enable; // [R6] [R7]
  assign bus.ready_for_data_dev = !input_data_flag; // [R4] [R9]

  // ****************************************
  // source side
  // ****************************************
  logic output_done_flag;
  logic src_s1;
  logic src_valid;
  logic dac_sync;
  byte_handshake_pkg::byte_t byte_out_register;
  logic wr_data;
  assign src_enable = i_talk && bus.attention_line_n; // [R17]
  assign wr_data = i_wr && (i_addr == `REG_DATA);
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      byte_out_register <= 8'h00;
    end else if (wr_data) begin
      byte_out_register <= i_wdata;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      output_done_flag <= 1'b1; // [R19]
    end else if (dac_sync && src_valid) begin
      output_done_flag <= 1'b1; // [R13] set wins over write
    end else if (wr_data) begin
      output_done_flag <= 1'b0; // [R11]
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      src_s1 <= 1'b1; // [R19]
      dac_sync <= 1'b0;
      src_valid <= 1'b0;
    end else begin
      src_s1 <= output_done_flag; // [R12]
      dac_sync <= bus.data_accepted; // [R13]
      // valid held until done, then dropped; new one waits for ready
      src_valid <= src_enable && !output_done_flag
                   && (src_valid || (!src_s1 && bus.ready_for_data)); // [R12] [R14] [R15]
    end
  end
  assign bus.data_valid_line_dev_n = !src_valid; // [R11]
  assign bus.dio_dev = byte_out_register;
  assign bus.dio_dev_oe = src_enable && !i_serial_poll_flag; // [R17]

  // ****************************************
  // interrupts and register reads
  // ****************************************
  logic [`IRQ_W-1:0] cause;
  logic [`IRQ_W-1:0] mask;
  logic in_flag_q;
  logic done_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      in_flag_q <= 1'b0;
      done_q <= 1'b1;
    end else begin
      in_flag_q <= input_data_flag;
      done_q <= output_done_flag;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cause <= 2'h0;
    end else begin
      // sticky events: new byte, output done; set beats write-one clear
      cause[`CAUSE_IN_BIT] <= decode_en ||
        (cause[`CAUSE_IN_BIT] && !(i_wr && i_addr == `REG_CAUSE && i_wdata[`CAUSE_IN_BIT]));
      cause[`CAUSE_OUT_BIT] <= (output_done_flag && !done_q) ||
        (cause[`CAUSE_OUT_BIT] && !(i_wr && i_addr == `REG_CAUSE && i_wdata[`CAUSE_OUT_BIT]));
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mask <= `MASK_RESET;
    end else if (i_wr && i_addr == `REG_MASK) begin
      mask <= i_wdata[`IRQ_W-1:0];
    end
  end
  // cause bit rises in the edge that latches the byte
  assign o_interrupt_request_n = !(|(cause & mask)); // [R5]
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `REG_CAUSE: o_rdata <= {4'h0, output_done_flag, input_data_flag, cause};
        `REG_STATE: o_rdata <= {5'h00, i_serial_poll_flag, i_listen, i_talk};
        `REG_MASK: o_rdata <= {6'h00, mask};
        `REG_DATA: o_rdata <= byte_in_register;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
  logic unused_in_flag;
  assign unused_in_flag = in_flag_q;
endmodule : byte_handshake_device

// [hdl/byte_handshake_pkg.sv]
// types for the instrument bus byte handshake
package byte_handshake_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait_dac = 2'b01,
    st_wait_release = 2'b10
  } talker_state_t;
endpackage : byte_handshake_pkg

// [hdl/byte_handshake_remote.sv]
// remote end: talker and listener driving the three-wire handshake
`timescale 1ns/1ps
`include "byte_handshake_cfg.svh"
module byte_handshake_remote (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // user side: send
  input wire logic i_send,
  input wire logic [7:0] i_send_byte,
  output logic o_send_busy,
  // user side: receive
  input wire logic i_listen_en,
  output logic o_recv_valid,
  output logic [7:0] o_recv_byte,
  // attention control
  input wire logic i_attention,
  // bus side
  byte_link_if.remote bus
);
  // ****************************************
  // talker
  // ****************************************
  byte_handshake_pkg::talker_state_t state;
  byte_handshake_pkg::byte_t tx_byte;
  logic settled;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= byte_handshake_pkg::st_idle;
      tx_byte <= 8'h00;
      settled <= 1'b0;
    end else begin
      case (state)
        byte_handshake_pkg::st_idle: begin
          if (i_send) begin
            tx_byte <= i_send_byte;
            settled <= 1'b0;
            state <= byte_handshake_pkg::st_wait_dac;
          end
        end
        byte_handshake_pkg::st_wait_dac: begin
          // one settle cycle before valid, then hold till accepted
          if (bus.ready_for_data) settled <= 1'b1; // [R2]
          if (settled && bus.data_accepted) begin
            settled <= 1'b0;
            state <= byte_handshake_pkg::st_wait_release; // [R7]
          end
        end
        byte_handshake_pkg::st_wait_release: begin
          if (!bus.data_accepted) state <= byte_handshake_pkg::st_idle;
        end
        default: state <= byte_handshake_pkg::st_idle;
      endcase
    end
  end
  assign bus.dio_far = tx_byte;
  assign bus.dio_far_oe = (state == byte_handshake_pkg::st_wait_dac); // [R2]
  assign bus.data_valid_line_far_n = !settled;
  assign bus.attention_line_n = !i_attention;
  assign o_send_busy = (state != byte_handshake_pkg::st_idle);

  // ****************************************
  // listener
  // ****************************************
  logic taken;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      taken <= 1'b0;
      o_recv_valid <= 1'b0;
      o_recv_byte <= 8'h00;
    end else begin
      o_recv_valid <= 1'b0;
      if (i_listen_en && !bus.data_valid_line_n && !taken) begin
        taken <= 1'b1; // [R16]
        o_recv_valid <= 1'b1;
        o_recv_byte <= bus.dio;
      end else if (bus.data_valid_line_n) begin
        taken <= 1'b0; // [R16]
      end
    end
  end
  // idle high when not listening so it never blocks
  assign bus.data_accepted_far = !i_listen_en || taken; // [R16]
  assign bus.ready_for_data_far = !i_listen_en || bus.data_valid_line_n; // [R16]
endmodule : byte_handshake_remote

// [hdl/byte_link_if.sv]
// wires of the three-wire byte handshake between device and remote party
`timescale 1ns/1ps
interface byte_link_if;
  logic [7:0] dio_dev;
  logic dio_dev_oe;
  logic [7:0] dio_far;
  logic dio_far_oe;
  logic data_valid_line_dev_n;
  logic data_valid_line_far_n;
  logic data_accepted_dev;
  logic data_accepted_far;
  logic ready_for_data_dev;
  logic ready_for_data_far;
  logic attention_line_n;
  logic [7:0] dio;
  logic data_valid_line_n;
  logic data_accepted;
  logic ready_for_data;
  // wired bus resolution: data active high when driven, valid low-true or-tied
  assign dio = dio_dev_oe ? dio_dev : (dio_far_oe ? dio_far : 8'hff);
  assign data_valid_line_n = data_valid_line_dev_n & data_valid_line_far_n;
  assign data_accepted = data_accepted_dev & data_accepted_far;
  assign ready_for_data = ready_for_data_dev & ready_for_data_far;
  modport device (
    input dio, data_valid_line_n, data_accepted, ready_for_data, attention_line_n,
    output dio_dev, dio_dev_oe, data_valid_line_dev_n, data_accepted_dev, ready_for_data_dev
  );
  modport remote (
    input dio, data_valid_line_n, data_accepted, ready_for_data,
    output dio_far, dio_far_oe, data_valid_line_far_n, data_accepted_far, ready_for_data_far,
    attention_line_n
  );
endinterface : byte_link_if

// [verification/byte_handshake_props.sv]
// concurrent checks on the byte handshake wires
`timescale 1ns/1ps
module byte_handshake_props (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // watched wires
  input wire logic [7:0] dio_dev,
  input wire logic dio_dev_oe,
  input wire logic data_valid_line_dev_n,
  input wire logic data_valid_line_far_n,
  input wire logic data_accepted_dev,
  input wire logic data_accepted_far,
  input wire logic ready_for_data_dev,
  input wire logic ready_for_data,
  input wire logic attention_line_n
);
  // ****************
  // handshake checks
  // ****************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_in_taken;
    $rose(data_accepted_dev) && !dio_dev_oe;
  endsequence
  sequence s_src_acked;
    $rose(data_accepted_far) && !data_valid_line_dev_n;
  endsequence
  a_reset_idle: assert property ($rose(i_arst_n) |->
    data_valid_line_dev_n && !data_accepted_dev && ready_for_data_dev) else $error("not idle");
  a_accept_cause: assert property (s_in_taken |->
    !data_valid_line_far_n && !$past(data_valid_line_far_n)) else $error("early accept");
  a_accept_ready: assert property (data_accepted_dev && !dio_dev_oe |->
    !ready_for_data_dev) else $error("ready high while accepted");
  a_accept_release: assert property (data_accepted_dev && !dio_dev_oe && data_valid_line_far_n |->
    ##[1:2] !data_accepted_dev) else $error("accepted stuck");
  a_valid_ready: assert property ($fell(data_valid_line_dev_n) |->
    $past(ready_for_data)) else $error("valid without ready");
  a_drive_talk: assert property (!data_valid_line_dev_n |->
    dio_dev_oe && attention_line_n) else $error("valid outside talk");
  a_src_release: assert property (s_src_acked |->
    ##[1:3] data_valid_line_dev_n) else $error("valid not released");
  a_src_hold: assert property (!data_valid_line_dev_n && !data_accepted_far |=>
    !data_valid_line_dev_n) else $error("valid dropped early");
  a_data_stable: assert property (!data_valid_line_dev_n && $past(!data_valid_line_dev_n)
    |-> $stable(dio_dev)) else $error("data moved");
endmodule : byte_handshake_props

// [verification/instrument_bus_byte_handshake_tb_top.sv]
// testbench joining device and remote ends of the byte handshake
`timescale 1ns/1ps
`include "byte_handshake_cfg.svh"
module instrument_bus_byte_handshake_tb_top;
  logic clk, rst_n, wr_s, rd_s, irq_n, talk, listen, poll, send, busy, listen_en, rv, attn;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, send_byte, rbyte, got;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  byte_link_if byte_link_if_i ();
  byte_handshake_device byte_handshake_device_i (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_interrupt_request_n(irq_n), .i_talk(talk), .i_listen(listen),
    .i_serial_poll_flag(poll), .bus(byte_link_if_i));
  byte_handshake_remote byte_handshake_remote_i (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_send(send), .i_send_byte(send_byte), .o_send_busy(busy), .i_listen_en(listen_en),
    .o_recv_valid(rv), .o_recv_byte(rbyte), .i_attention(attn), .bus(byte_link_if_i));
  byte_handshake_props byte_handshake_props_i (.i_ref_clk(clk), .i_arst_n(rst_n),
    .dio_dev(byte_link_if_i.dio_dev), .dio_dev_oe(byte_link_if_i.dio_dev_oe),
    .data_valid_line_dev_n(byte_link_if_i.data_valid_line_dev_n),
    .data_valid_line_far_n(byte_link_if_i.data_valid_line_far_n),
    .data_accepted_dev(byte_link_if_i.data_accepted_dev),
    .data_accepted_far(byte_link_if_i.data_accepted_far),
    .ready_for_data_dev(byte_link_if_i.ready_for_data_dev),
    .ready_for_data(byte_link_if_i.ready_for_data),
    .attention_line_n(byte_link_if_i.attention_line_n));
  // *************
  // bus tasks
  // *************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rchk
  // polling keeps the wait bounded even if the flag never comes
  task automatic wait_cause(input logic [7:0] m);
    logic [7:0] d;
    for (int k = 0; k < 200; k++) begin
      rd(`REG_CAUSE, d);
      if ((d & m) == m) return;
    end
    n_mismatch++;
    $display("[ERR] %0t cause bit never set", $time);
  endtask : wait_cause
  // *************
  // scenarios
  // *************
  task automatic t_accept();
    @(posedge clk);
    send_byte <= 8'ha5;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (20) @(posedge clk);
    rchk(`REG_CAUSE, 8'h08);
    attn <= 1'b1;
    wait_cause(8'h01);
    rchk(`REG_CAUSE, 8'h0d);
    chk({7'h0, irq_n}, 8'h01);
    wr(`REG_MASK, 8'h01);
    chk({7'h0, irq_n}, 8'h00);
    rchk(`REG_DATA, 8'ha5);
    rchk(`REG_CAUSE, 8'h09);
    wr(`REG_CAUSE, 8'h01);
    chk({7'h0, irq_n}, 8'h01);
    chk({7'h0, busy}, 8'h00);
    attn <= 1'b0;
  endtask : t_accept
  // talk held off first so the cleared done flag can be seen without a race
  task automatic t_source();
    listen_en <= 1'b1;
    rchk(`REG_CAUSE, 8'h08);
    wr(`REG_DATA, 8'h5a);
    repeat (10) @(posedge clk);
    rchk(`REG_CAUSE, 8'h00);
    chk(got, 8'h00);
    talk <= 1'b1;
    wait_cause(8'h02);
    rchk(`REG_CAUSE, 8'h0a);
    chk(got, 8'h5a);
    wr(`REG_CAUSE, 8'h02);
    rchk(`REG_CAUSE, 8'h08);
    talk <= 1'b0;
  endtask : t_source
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      got <= rbyte;
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_n, wr_s, rd_s, talk, listen, poll, send, listen_en, attn} = '0;
    {addr, wdata, send_byte, got} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`REG_CAUSE, 8'h08);
    chk({7'h0, irq_n}, 8'h01);
    t_accept();
    t_source();
    test_done();
  end
endmodule : instrument_bus_byte_handshake_tb_top
